// ==== rtl/irq_sources.sv ====
// Purpose: Shared interrupt collection and its local sources.
// Assumes: Core takes the request levels and runs its own arbiter.
// Notes:   Converter analog part is outside; it reports done.
// Overview of operation
// - Clock line low twelve cycles sets flag.
// - Six requests presented to the core.
// - Fixed order, lowest vector wins ties.
// - Shared request ORs seven source flags.
// - Readable pending flag per shared source.
// - Mask bits 0..6 enable each source.
// - Last request driven only by I2C.
// - Enable bits 2,5; bit 7 masks all.
// - Priority bits 2 and 5 select level.
// - Reload timer unit is 1024 cycles.
// - Reload period is unit times value+1.
// - Parabola timer counts every system cycle.
// - Parabola period is 16-bit value+1 cycles.
// - Two-bit select picks one of four inputs.
// - Done clears go bit, sets flag.
// - Six-bit result readable by software.
// - Writing one clears a pending flag.
// - Flag sets only when mask bit set.
// - Fixed flag bit positions zero to six.
//
// Strobed register access and the register offsets were decided locally.
`timescale 1ns/10ps
module irq_sources #(
    parameter int HOLD = irq_src_pkg::LOW_HOLD_CYCLES,
    parameter int UNIT = irq_src_pkg::TICK_UNIT_CYCLES
) (
    // Clock and reset.
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       clk_en,
    // Register port.
    input  wire logic [3:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata_ff,
    // Source inputs.
    input  wire logic       display_clock_line,
    input  wire logic       safe_area_output,
    input  wire logic       vert_event,
    input  wire logic       mode1_event,
    input  wire logic       i2c_request,
    input  wire logic       external_request_zero,
    input  wire logic       timer_zero_overflow,
    input  wire logic       timer_one_overflow,
    input  wire logic       serial_rx_tx_flags,
    // Converter.
    input  wire logic       conv_done,
    input  wire logic [5:0] conv_data,
    output logic      [1:0] conv_channel_ff,
    output logic            conv_run_ff,
    // Core requests in vector order, with level.
    output logic      [5:0] req_ff,
    output logic      [5:0] req_high_ff,
    output logic      [5:0] req_grant_ff
);
    localparam int HW = $clog2(HOLD + 1);

    logic [6:0]  pending_source_flags;
    logic [6:0]  source_mask_bits;
    logic [7:0]  first_control_reg;
    logic [5:0]  result_ff;
    logic [7:0]  reload_ff;
    logic [7:0]  parabola_reload_low;
    logic [7:0]  parabola_reload_high;
    logic [7:0]  interrupt_enable_reg;
    logic [7:0]  priority_select_reg;
    logic [HW-1:0] low_cnt_ff;
    logic        line_prev_ff;
    logic        low_seen_ff;
    logic        tmr_exp;
    logic        para_exp;

    // ****************************************************************
    // Register decode.
    // ****************************************************************
    wire wr_pend  = wr && (addr == irq_src_pkg::OFS_PENDING);
    wire wr_mask  = wr && (addr == irq_src_pkg::OFS_MASK);
    wire wr_ctrl  = wr && (addr == irq_src_pkg::OFS_CTRL1);
    wire wr_rld   = wr && (addr == irq_src_pkg::OFS_RELOAD);
    wire wr_plo   = wr && (addr == irq_src_pkg::OFS_PARA_LO);
    wire wr_phi   = wr && (addr == irq_src_pkg::OFS_PARA_HI);
    wire wr_ie    = wr && (addr == irq_src_pkg::OFS_IE);
    wire wr_ip    = wr && (addr == irq_src_pkg::OFS_IP);

    wire [7:0] rd_mux =
        (addr == irq_src_pkg::OFS_PENDING) ? {1'b0, pending_source_flags} :
        (addr == irq_src_pkg::OFS_MASK)    ? {1'b0, source_mask_bits} :
        (addr == irq_src_pkg::OFS_CTRL1)   ? first_control_reg :
        (addr == irq_src_pkg::OFS_RESULT)  ? {2'b00, result_ff} :
        (addr == irq_src_pkg::OFS_RELOAD)  ? reload_ff :
        (addr == irq_src_pkg::OFS_PARA_LO) ? parabola_reload_low :
        (addr == irq_src_pkg::OFS_PARA_HI) ? parabola_reload_high :
        (addr == irq_src_pkg::OFS_IE)      ? interrupt_enable_reg :
        (addr == irq_src_pkg::OFS_IP)      ? priority_select_reg : 8'h00;

    // ****************************************************************
    // Clock line low detector.
    // ****************************************************************
    wire fall      = line_prev_ff && !display_clock_line;
    wire low_hit   = !display_clock_line && low_seen_ff && (low_cnt_ff == HW'(HOLD - 1));
    wire [HW-1:0] nxt_low_cnt = fall ? '0 : low_cnt_ff + HW'(1);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            line_prev_ff <= 1'b1;
            low_seen_ff  <= 1'b0;
            low_cnt_ff   <= '0;
        end else if (clk_en) begin
            line_prev_ff <= display_clock_line;
            if (display_clock_line || low_hit) begin
                low_seen_ff <= 1'b0;
            end else if (fall) begin
                low_seen_ff <= 1'b1;
            end
            if (fall || low_seen_ff) begin
                low_cnt_ff <= nxt_low_cnt;
            end
        end
    end

    // ****************************************************************
    // Timers.
    // ****************************************************************
    reload_timer #(.W(8), .PRE(UNIT)) u_tick_tmr (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .clk_en    (clk_en),
        .reload    (reload_ff),
        .expire_ff (tmr_exp)
    );

    reload_timer #(.W(16), .PRE(1)) u_para_tmr (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .clk_en    (clk_en),
        .reload    ({parabola_reload_high, parabola_reload_low}),
        .expire_ff (para_exp)
    );

    // ****************************************************************
    // Pending flags.
    // ****************************************************************
    wire done_evt = conv_done && conv_run_ff;
    wire [6:0] src_evt = {mode1_event, para_exp, vert_event, safe_area_output,
                          tmr_exp, done_evt, low_hit};
    wire [6:0] clr_bits = wr_pend ? wdata[6:0] : 7'h00;
    wire [6:0] set_bits = src_evt & source_mask_bits;
    wire [6:0] nxt_pend = (pending_source_flags & ~clr_bits) | set_bits;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pending_source_flags <= '0;
            source_mask_bits     <= '0;
        end else if (clk_en) begin
            pending_source_flags <= nxt_pend;
            if (wr_mask) begin
                source_mask_bits <= wdata[6:0];
            end
        end
    end

    // ****************************************************************
    // Converter control.
    // ****************************************************************
    wire nxt_go = wr_ctrl ? wdata[irq_src_pkg::BIT_GO] :
                  (done_evt ? 1'b0 : conv_run_ff);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            first_control_reg <= irq_src_pkg::RST_BYTE;
            conv_run_ff       <= 1'b0;
            conv_channel_ff   <= 2'b00;
            result_ff         <= '0;
        end else if (clk_en) begin
            conv_run_ff <= nxt_go;
            if (wr_ctrl) begin
                first_control_reg <= wdata;
                conv_channel_ff   <= {wdata[irq_src_pkg::BIT_CH_HI],
                                      wdata[irq_src_pkg::BIT_CH_LO]};
            end else begin
                first_control_reg[irq_src_pkg::BIT_GO] <= nxt_go;
            end
            if (done_evt) begin
                result_ff <= conv_data;
            end
        end
    end

    // ****************************************************************
    // Remaining registers.
    // ****************************************************************
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            reload_ff            <= irq_src_pkg::RST_BYTE;
            parabola_reload_low  <= irq_src_pkg::RST_BYTE;
            parabola_reload_high <= irq_src_pkg::RST_BYTE;
            interrupt_enable_reg <= irq_src_pkg::RST_BYTE;
            priority_select_reg  <= irq_src_pkg::RST_BYTE;
            rdata_ff             <= 8'h00;
        end else if (clk_en) begin
            if (wr_rld) reload_ff <= wdata;
            if (wr_plo) parabola_reload_low <= wdata;
            if (wr_phi) parabola_reload_high <= wdata;
            if (wr_ie) interrupt_enable_reg <= wdata;
            if (wr_ip) priority_select_reg <= wdata;
            rdata_ff <= rd ? rd_mux : 8'h00;
        end
    end

    // ****************************************************************
    // Requests to the core.
    // ****************************************************************
    wire shared_req = |pending_source_flags;
    wire [5:0] raw  = {i2c_request, serial_rx_tx_flags, timer_one_overflow,
                       shared_req, timer_zero_overflow, external_request_zero};
    wire [5:0] en   = interrupt_enable_reg[7] ? interrupt_enable_reg[5:0] : 6'h00;
    wire [5:0] act  = raw & en;
    wire [5:0] hi   = act & priority_select_reg[5:0];
    wire [5:0] pool = (|hi) ? hi : act;
    wire [5:0] win  = pool & ~(pool - 6'h01);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            req_ff       <= '0;
            req_high_ff  <= '0;
            req_grant_ff <= '0;
        end else if (clk_en) begin
            req_ff       <= act;
            req_high_ff  <= hi;
            req_grant_ff <= win;
        end
    end
endmodule : irq_sources

// ==== shared/irq_src_pkg.sv ====
// Purpose: Constants shared by the interrupt source block.
// Assumes: 10 MHz system clock, 8-bit register port.
// Notes:   Offsets are byte indexes on the register port.
package irq_src_pkg;
    localparam int          CLK_HZ           = 10_000_000;
    localparam int          LOW_HOLD_CYCLES  = 12;
    localparam int          TICK_UNIT_CYCLES = 1024;
    localparam int          NUM_SRC          = 7;
    // Register indexes.
    localparam logic [3:0]  OFS_PENDING      = 4'h0;
    localparam logic [3:0]  OFS_MASK         = 4'h1;
    localparam logic [3:0]  OFS_CTRL1        = 4'h2;
    localparam logic [3:0]  OFS_RESULT       = 4'h3;
    localparam logic [3:0]  OFS_RELOAD       = 4'h4;
    localparam logic [3:0]  OFS_PARA_LO      = 4'h5;
    localparam logic [3:0]  OFS_PARA_HI      = 4'h6;
    localparam logic [3:0]  OFS_IE           = 4'h7;
    localparam logic [3:0]  OFS_IP           = 4'h8;
    // Pending flag positions.
    localparam int          BIT_CLK_LOW      = 0;
    localparam int          BIT_CONV_DONE    = 1;
    localparam int          BIT_RELOAD_TMR   = 2;
    localparam int          BIT_SAFE_AREA    = 3;
    localparam int          BIT_VERT_EVENT   = 4;
    localparam int          BIT_PARABOLA     = 5;
    localparam int          BIT_MODE1        = 6;
    // First control register fields.
    localparam int          BIT_CH_LO        = 0;
    localparam int          BIT_CH_HI        = 1;
    localparam int          BIT_GO           = 2;
    // Enable and priority fields.
    localparam int          BIT_IE_SHARED    = 2;
    localparam int          BIT_IE_DDC       = 5;
    localparam int          BIT_IE_ALL       = 7;
    // Reset values.
    localparam logic [7:0]  RST_BYTE         = 8'h00;
endpackage : irq_src_pkg

// ==== rtl/reload_timer.sv ====
// Purpose: Auto-reload down counter with a prescaled tick.
// Assumes: Reload value is sampled at each expiry.
// Notes:   Pulse lasts one enabled cycle.
`timescale 1ns/10ps
module reload_timer #(
    parameter int W   = 8,
    parameter int PRE = 1
) (
    // Clock and reset.
    input  wire logic         sys_clk,
    input  wire logic         rst,
    input  wire logic         clk_en,
    // Control.
    input  wire logic [W-1:0] reload,
    // Event.
    output logic              expire_ff
);
    localparam int PW = (PRE > 1) ? $clog2(PRE) : 1;
    logic [PW-1:0] pre_ff;
    logic [W-1:0]  cnt_ff;
    wire           tick     = (PRE == 1) || (pre_ff == PW'(PRE - 1));
    wire           at_zero  = (cnt_ff == '0);
    wire [PW-1:0]  nxt_pre  = tick ? '0 : pre_ff + PW'(1);
    wire [W-1:0]   nxt_cnt  = at_zero ? reload : cnt_ff - W'(1);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pre_ff    <= '0;
            cnt_ff    <= '0;
            expire_ff <= 1'b0;
        end else if (clk_en) begin
            pre_ff    <= nxt_pre;
            if (tick) begin
                cnt_ff <= nxt_cnt;
            end
            expire_ff <= tick && at_zero;
        end
    end
endmodule : reload_timer

// ==== dv/conv_model.sv ====
// Purpose: Converter model answering a started conversion.
// Assumes: DELAY+1 cycles per conversion.
// Notes:   Result is {channel, 4'h5}.
`timescale 1ns/10ps
module conv_model #(
    parameter int DELAY = 5
) (
    // Clock and control.
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       conv_run_ff,
    input  wire logic [1:0] conv_channel_ff,
    // Answer.
    output logic            conv_done,
    output logic      [5:0] conv_data
);
    int cnt;
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cnt <= 0;
            conv_done <= 1'b0;
            conv_data <= 6'h00;
        end else if (conv_run_ff && !conv_done && cnt < DELAY) begin
            cnt <= cnt + 1;
        end else if (conv_run_ff && !conv_done) begin
            cnt <= 0;
            conv_done <= 1'b1;
            conv_data <= {conv_channel_ff, 4'h5};
        end else begin
            conv_done <= 1'b0;
            conv_data <= ~conv_data;
        end
    end
endmodule : conv_model

// ==== dv/irq_sources_checker.sv ====
// Purpose: Port assertions for the interrupt source block.
// Assumes: One clock, reset active high.
// Notes:   The enable byte is shadowed from writes.
`timescale 1ns/10ps
module irq_sources_checker #(
    parameter int HOLD = 12,
    parameter int UNIT = 1024
) (
    // Clock, reset and register port.
    input wire logic       sys_clk,
    input wire logic       rst,
    input wire logic       clk_en,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] rdata_ff,
    // Sources, converter and requests.
    input wire logic       i2c_request,
    input wire logic       external_request_zero,
    input wire logic       conv_done,
    input wire logic [1:0] conv_channel_ff,
    input wire logic       conv_run_ff,
    input wire logic [5:0] req_ff,
    input wire logic [5:0] req_high_ff,
    input wire logic [5:0] req_grant_ff
);
    logic [7:0] ie_ff;
    wire        ie_wr = clk_en && wr && (addr == irq_src_pkg::OFS_IE);
    wire        c1_wr = clk_en && wr && (addr == irq_src_pkg::OFS_CTRL1);
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) ie_ff <= 8'h00;
        else if (ie_wr) ie_ff <= wdata;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // ****************
    // Assertions.
    // ****************
    AST_RD_IDLE: assert property ((clk_en && !rd) |=> rdata_ff == 8'h00)
        else $error("read data not idle");
    AST_ONEHOT: assert property ($onehot0(req_grant_ff))
        else $error("grant not one-hot");
    AST_GRANT_REQ: assert property ((req_grant_ff & ~req_ff) == 6'h00)
        else $error("grant without request");
    AST_HIGH_REQ: assert property ((req_high_ff & ~req_ff) == 6'h00)
        else $error("high level without request");
    AST_TOP_WINS: assert property (
        (req_ff[0] && (req_high_ff[0] || req_high_ff == 6'h00)) |-> req_grant_ff[0])
        else $error("first vector lost");
    AST_I2C: assert property (clk_en |=> req_ff[5] ==
        ($past(i2c_request) && $past(ie_ff[7]) && $past(ie_ff[5])))
        else $error("last request wrong");
    AST_EXT0: assert property (clk_en |=> req_ff[0] ==
        ($past(external_request_zero) && $past(ie_ff[7]) && $past(ie_ff[0])))
        else $error("first request wrong");
    AST_SHARED_EN: assert property (req_ff[2] |-> $past(ie_ff[2]) && $past(ie_ff[7]))
        else $error("shared request while disabled");
    AST_GO_SET: assert property (c1_wr |=> conv_run_ff == $past(wdata[2])
        && conv_channel_ff == $past(wdata[1:0]))
        else $error("control write not taken");
    AST_GO_CLEAR: assert property ((clk_en && conv_run_ff && conv_done && !c1_wr)
        |=> !conv_run_ff)
        else $error("go bit not cleared");
    CVR_DONE: cover property (conv_run_ff && conv_done);
    CVR_I2C: cover property (req_grant_ff[5]);
    CVR_SHARED: cover property (req_ff[2]);
endmodule : irq_sources_checker
bind irq_sources irq_sources_checker #(.HOLD(HOLD), .UNIT(UNIT)) irq_sources_checker_inst (
    .sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata_ff(rdata_ff), .i2c_request(i2c_request),
    .external_request_zero(external_request_zero), .conv_done(conv_done),
    .conv_channel_ff(conv_channel_ff), .conv_run_ff(conv_run_ff), .req_ff(req_ff),
    .req_high_ff(req_high_ff), .req_grant_ff(req_grant_ff));

// ==== dv/irq_sources_tb.sv ====
// Purpose: Register-level tests of the interrupt source block.
// Assumes: Shortened timer unit of 4 cycles.
// Notes:   Reads are checked in the cycle after the strobe.
`timescale 1ns/10ps
module irq_sources_tb;
    logic       sys_clk = 1'b0;
    logic       rst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic       dcl = 1'b1;
    logic [2:0] ev = 3'h0;
    logic       i2c = 1'b0;
    logic       ext0 = 1'b0;
    logic [2:0] core_src = 3'h0;
    logic       ce = 1'b1;
    logic       conv_done, conv_run_ff;
    logic [5:0] conv_data, req_ff, req_high_ff, req_grant_ff;
    logic [7:0] rdata_ff;
    logic [1:0] conv_channel_ff;
    int         miscompares = 0;
    int         n_checks = 0;
    int         cyc = 0;
    always #50 sys_clk = ~sys_clk;
    always @(posedge sys_clk) cyc <= cyc + 1;
    irq_sources #(.HOLD(12), .UNIT(4)) irq_sources_inst (.sys_clk(sys_clk), .rst(rst),
        .clk_en(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_ff(rdata_ff),
        .display_clock_line(dcl), .safe_area_output(ev[0]), .vert_event(ev[1]),
        .mode1_event(ev[2]), .i2c_request(i2c), .external_request_zero(ext0),
        .timer_zero_overflow(core_src[0]), .timer_one_overflow(core_src[1]),
        .serial_rx_tx_flags(core_src[2]),
        .conv_done(conv_done), .conv_data(conv_data), .conv_channel_ff(conv_channel_ff),
        .conv_run_ff(conv_run_ff), .req_ff(req_ff), .req_high_ff(req_high_ff),
        .req_grant_ff(req_grant_ff));
    conv_model conv_model_inst (.sys_clk(sys_clk), .rst(rst), .conv_run_ff(conv_run_ff),
        .conv_channel_ff(conv_channel_ff), .conv_done(conv_done), .conv_data(conv_data));
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk) {wr, addr, wdata} <= {1'b1, a, d};
        @(posedge sys_clk) wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
        @(posedge sys_clk) {rd, addr} <= {1'b1, a};
        @(posedge sys_clk) rd <= 1'b0;
        @(negedge sys_clk) check("register", {8'h00, rdata_ff}, {8'h00, e});
    endtask : rd_chk
    task automatic wait_rise();
        int k;
        k = 0;
        while (req_ff[2] === 1'b1 && k < 3000) begin @(negedge sys_clk); k++; end
        while (req_ff[2] !== 1'b1 && k < 3000) begin @(negedge sys_clk); k++; end
        if (k >= 3000) miscompares++;
    endtask : wait_rise
    task automatic gap(input logic [7:0] m, input int exp);
        int t0;
        wr_reg(irq_src_pkg::OFS_MASK, m);
        wr_reg(irq_src_pkg::OFS_PENDING, 8'h7F);
        wr_reg(irq_src_pkg::OFS_PENDING, 8'h7F);
        wait_rise();
        t0 = cyc;
        wr_reg(irq_src_pkg::OFS_PENDING, 8'h7F);
        wait_rise();
        check("period", 16'(cyc - t0), 16'(exp));
    endtask : gap
    task automatic close_out();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : close_out
    initial begin
        #2_000_000;
        miscompares++;
        close_out();
    end
    initial begin
        logic [7:0] fb;
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        wr_reg(4'h9, 8'hFF);
        rd_chk(4'h9, 8'h00);
        rd_chk(irq_src_pkg::OFS_MASK, 8'h00);
        rd_chk(irq_src_pkg::OFS_CTRL1, 8'h00);
        $display("test reset done");
        wr_reg(irq_src_pkg::OFS_IE, 8'h84);
        for (int i = 0; i < 3; i++) begin
            fb = (i == 0) ? 8'h08 : (i == 1) ? 8'h10 : 8'h40;
            wr_reg(irq_src_pkg::OFS_MASK, fb);
            @(posedge sys_clk) ev <= 3'(1 << i);
            @(posedge sys_clk) ev <= 3'h0;
            rd_chk(irq_src_pkg::OFS_PENDING, fb);
            check("shared", {15'h0, req_ff[2]}, 16'h0001);
            wr_reg(irq_src_pkg::OFS_PENDING, 8'h00);
            rd_chk(irq_src_pkg::OFS_PENDING, fb);
            check("shared held", {15'h0, req_ff[2]}, 16'h0001);
            wr_reg(irq_src_pkg::OFS_PENDING, fb);
            rd_chk(irq_src_pkg::OFS_PENDING, 8'h00);
            wr_reg(irq_src_pkg::OFS_MASK, ~fb & 8'h5B);
            @(posedge sys_clk) ev <= 3'(1 << i);
            @(posedge sys_clk) ev <= 3'h0;
            rd_chk(irq_src_pkg::OFS_PENDING, 8'h00);
        end
        $display("test events done");
        wr_reg(irq_src_pkg::OFS_MASK, 8'h01);
        @(posedge sys_clk) dcl <= 1'b0;
        repeat (10) @(posedge sys_clk);
        dcl <= 1'b1;
        rd_chk(irq_src_pkg::OFS_PENDING, 8'h00);
        @(posedge sys_clk) dcl <= 1'b0;
        repeat (14) @(posedge sys_clk);
        dcl <= 1'b1;
        rd_chk(irq_src_pkg::OFS_PENDING, 8'h01);
        $display("test clock line done");
        wr_reg(irq_src_pkg::OFS_RELOAD, 8'h02);
        gap(8'h04, 12);
        wr_reg(irq_src_pkg::OFS_PARA_LO, 8'h02);
        wr_reg(irq_src_pkg::OFS_PARA_HI, 8'h01);
        gap(8'h20, 259);
        $display("test timers done");
        wr_reg(irq_src_pkg::OFS_MASK, 8'h02);
        wr_reg(irq_src_pkg::OFS_PENDING, 8'h7F);
        for (int ch = 0; ch < 4; ch++) begin
            wr_reg(irq_src_pkg::OFS_CTRL1, {6'h01, 2'(ch)});
            @(negedge sys_clk) check("channel", {14'h0, conv_channel_ff}, 16'(ch));
            for (int k = 0; k < 50 && conv_run_ff !== 1'b0; k++) @(negedge sys_clk);
            check("go", {15'h0, conv_run_ff}, 16'h0000);
            rd_chk(irq_src_pkg::OFS_RESULT, {2'h0, 2'(ch), 4'h5});
            rd_chk(irq_src_pkg::OFS_PENDING, 8'h02);
            wr_reg(irq_src_pkg::OFS_PENDING, 8'h02);
        end
        $display("test converter done");
        wr_reg(irq_src_pkg::OFS_IE, 8'hBF);
        wr_reg(irq_src_pkg::OFS_IP, 8'h20);
        @(posedge sys_clk) {ext0, i2c, core_src} <= 5'h1F;
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk) check("requests", {10'h0, req_ff}, 16'h003B);
        check("grant high", {10'h0, req_grant_ff}, 16'h0020);
        check("level", {10'h0, req_high_ff}, 16'h0020);
        wr_reg(irq_src_pkg::OFS_IP, 8'h00);
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk) check("grant order", {10'h0, req_grant_ff}, 16'h0001);
        @(posedge sys_clk) ext0 <= 1'b0;
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk) check("grant next", {10'h0, req_grant_ff}, 16'h0002);
        wr_reg(irq_src_pkg::OFS_IE, 8'h3F);
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk) check("all off", {10'h0, req_ff}, 16'h0000);
        $display("test priority done");
        @(posedge sys_clk) {i2c, core_src} <= 4'h0;
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        rd_chk(irq_src_pkg::OFS_IE, 8'h00);
        rd_chk(irq_src_pkg::OFS_PARA_HI, 8'h00);
        @(posedge sys_clk) ce <= 1'b0;
        wr_reg(irq_src_pkg::OFS_RELOAD, 8'h55);
        @(posedge sys_clk) ce <= 1'b1;
        rd_chk(irq_src_pkg::OFS_RELOAD, 8'h00);
        $display("test reset and freeze done");
        close_out();
    end
endmodule : irq_sources_tb
